// ### hdl/gpio_route_pkg.sv
// Purpose: Shared constants for the GPIO and terminal routing block
// Assumes: AXI4-Lite, 32-bit data, 12-bit byte address
// Notes:   Register index times four gives the byte address
package gpio_route_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_CHG = 10'h088;
   localparam logic [9:0] IDX_GPI = 10'h08a;
   localparam logic [9:0] IDX_GPO = 10'h08b;
   localparam logic [9:0] IDX_ROUTE = 10'h08c;
   localparam logic [11:0] ADDR_CHG = {IDX_CHG, 2'b00};
   localparam logic [11:0] ADDR_GPI = {IDX_GPI, 2'b00};
   localparam logic [11:0] ADDR_GPO = {IDX_GPO, 2'b00};
   localparam logic [11:0] ADDR_ROUTE = {IDX_ROUTE, 2'b00};
   localparam int AW = 12;
   localparam int NGP = 5;
   localparam int NT = 7;
   localparam int FW = 4;
   // ----------------------------------------------------------------
   // Reset values and fields
   // ----------------------------------------------------------------
   localparam logic [31:0] ROUTE_RST = 32'h0000_1000;
   localparam logic [31:0] ROUTE_LIVE = 32'h0fff_ffff;
   localparam logic [4:0] GPO_RST = 5'h00;
   localparam logic [6:0] OE_N_RST = 7'h7f;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Routing codes shared by several terminals
   localparam logic [3:0] C_GPI = 4'h0;
   localparam logic [3:0] C_GPO = 4'h1;
   localparam logic [3:0] C_ALT = 4'h1;
   localparam logic [3:0] C_PWM = 4'h8;
   localparam logic [3:0] C_WAKE = 4'he;
   // Source vector positions; 15:0 are the IRQ lines
   localparam int S_INTA = 16;
   localparam int S_INTB = 17;
   localparam int S_INTC = 18;
   localparam int S_INTD = 19;
   localparam int S_PWM = 20;
   localparam int S_FW = 21;
   localparam int S_SKT = 22;
   localparam int S_LEDA = 23;
   localparam int S_RI = 24;
   localparam int S_TMUX = 25;
   localparam int S_WAKE = 26;
   localparam int S_SCTX = 27;
   localparam int S_CLK = 28;
   localparam int S_SER = 29;
   localparam int S_LOCK = 30;
   // IRQ codes legal per terminal, terminal 6 first
   localparam logic [6:0][15:0] IRQ_OK = {16'hfffc, 16'h8228,
      16'h8218, 16'hfffc, 16'h0438, 16'h8e28, 16'h8e38};
   // Bit 3 valid, bits 2:0 GPIO index, terminal 6 first
   localparam logic [6:0][3:0] GP_MAP = {4'h0, 4'hc, 4'hb, 4'h0,
      4'ha, 4'h9, 4'h8};
   localparam logic [4:0][2:0] GPI_TERM = {3'd5, 3'd4, 3'd2, 3'd1,
      3'd0};
endpackage

// ### hdl/gpio_route.sv
// Purpose: GPIO levels, input change flags and routing of seven
//          multifunction terminals, behind an AXI4-Lite slave
// Assumes: arst_n_i is the global reset; pins synchronous
// Notes:   Terminals drive only while their code selects an output
// Functional notes
// - Input register bits 4:0 return the current general input levels
// - Bits 7:5 of input and output registers read zero, ignore writes
// - Output register bits 4:0 are writable, drive outputs, reset zero
// - Routing register bits 31:28 always read zero
// - Field 27:24 routes terminal 6: clock run or IRQ2..IRQ15
// - Field 23:20 routes terminal 5 by its code table
// - Field 19:16 routes terminal 4 by its code table
// - Field 15:12 routes terminal 3: serial IRQ or IRQ2..15, reset 0001
// - Field 11:8 routes terminal 2 by its code table
// - Field 7:4 routes terminal 1 by its code table
// - Field 3:0 routes terminal 0 by its code table
// - Routing resets to 0x00001000; only global reset clears fields
// - Routing defaults may be loaded from serial EEPROM at startup
// - A routed input changing level sets its sticky change flag
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
module gpio_route (
   // Clock and global reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // AXI4-Lite slave
   input wire logic [gpio_route_pkg::AW-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [gpio_route_pkg::AW-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Serial EEPROM loader
   input wire logic eeprom_load_i,
   input wire logic [31:0] eeprom_route_i,
   // Internal signals to route
   input wire logic [15:0] irq_i,
   input wire logic [3:0] pci_int_i,
   input wire logic card_audio_pwm_i,
   input wire logic firewire_activity_led_i,
   input wire logic socket_activity_led_i,
   input wire logic led_a_one_i,
   input wire logic ring_indicate_output_i,
   input wire logic test_multiplexer_output_i,
   input wire logic wake_event_output_i,
   input wire logic smartcard_debug_transmit_i,
   input wire logic clkrun_out_i,
   input wire logic clkrun_oe_n_i,
   input wire logic serialized_interrupt_out_i,
   input wire logic serialized_interrupt_oe_n_i,
   input wire logic lock_out_i,
   input wire logic lock_oe_n_i,
   // Signals taken from terminals
   output logic smartcard_debug_receive_o,
   output logic clkrun_in_o,
   output logic serialized_interrupt_in_o,
   output logic lock_in_o,
   // Multifunction terminals
   input wire logic [6:0] term_in_i,
   output logic [6:0] term_out_o,
   output logic [6:0] term_oe_n_o
);
   import gpio_route_pkg::*;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [AW-1:0] rd_addr;
      logic aw_have;
      logic w_have;
      logic [AW-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [4:0] general_output_levels;
      logic [4:0] general_input_levels;
      logic [4:0] chg;
      logic [31:0] route;
      logic [6:0] term_out;
      logic [6:0] term_oe_n;
      logic sc_rx;
      logic clk_in;
      logic ser_in;
      logic lock_in;
   } state_t;

   localparam state_t ST_RST = '{route: ROUTE_RST, general_output_levels: GPO_RST,
      term_oe_n: OE_N_RST, default: '0};

   state_t s_q;
   state_t s_d;
   logic [30:0] src;

   // ----------------------------------------------------------------
   // Terminal decode
   // ----------------------------------------------------------------
   // Returns {oe_n, level}; reserved and input codes leave it undriven
   function automatic logic [1:0] term_drive(input logic [2:0] t,
      input logic [3:0] c, input logic [30:0] s, input logic g,
      input logic [2:0] boe);
      logic [1:0] r;
      r = 2'b10;
      if (IRQ_OK[t][c]) begin
         r = {1'b0, s[c]};
      end
      if (t == 3'd6 || t == 3'd3) begin
         if (c == C_ALT) begin
            r = (t == 3'd6) ? {boe[0], s[S_CLK]} :
               {boe[1], s[S_SER]};
         end
      end else begin
         if (c == C_GPO) begin
            r = {1'b0, g};
         end
         if (c == C_PWM) begin
            r = {1'b0, s[S_PWM]};
         end
         if (c == C_WAKE) begin
            r = {1'b0, s[S_WAKE]};
         end
         case ({t, c})
            {3'd5, 4'hb}, {3'd1, 4'h4}: r = {1'b0, s[S_FW]};
            {3'd5, 4'hc}, {3'd1, 4'hc}, {3'd0, 4'hc}: r = {1'b0, s[S_LEDA]};
            {3'd5, 4'hd}, {3'd4, 4'hd}: r = {1'b0, s[S_SKT]};
            {3'd4, 4'h2}: r = {boe[2], s[S_LOCK]};
            {3'd4, 4'h5}: r = {1'b0, s[S_SCTX]};
            {3'd4, 4'ha}: r = {1'b0, s[S_INTD]};
            {3'd4, 4'hc}, {3'd2, 4'hc}: r = {1'b0, s[S_RI]};
            {3'd2, 4'hb}: r = {1'b0, s[S_INTC]};
            {3'd2, 4'hd}: r = {1'b0, s[S_TMUX]};
            {3'd2, 4'hf}: r = {1'b0, s[7]};
            {3'd1, 4'h2}: r = {1'b0, s[S_INTB]};
            {3'd0, 4'h2}: r = {1'b0, s[S_INTA]};
            default: ;
         endcase
      end
      return r;
   endfunction

   function automatic logic [3:0] field(input logic [31:0] rt,
      input logic [2:0] t);
      return rt[FW*t +: FW];
   endfunction

   assign src = {lock_out_i, serialized_interrupt_out_i, clkrun_out_i,
      smartcard_debug_transmit_i, wake_event_output_i,
      test_multiplexer_output_i, ring_indicate_output_i, led_a_one_i,
      socket_activity_led_i, firewire_activity_led_i, card_audio_pwm_i,
      pci_int_i, irq_i};

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [3:0] m;
      logic [2:0] t;
      logic [1:0] dr;
      logic [31:0] rt;
      logic [4:0] ev;
      m = '0;
      t = '0;
      dr = '0;
      rt = '0;
      ev = '0;
      s_d = s_q;
      // Write address and data are taken independently
      if (s_axi_awvalid_i && s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.awaddr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.wdata = s_axi_wdata_i;
         s_d.wstrb = s_axi_wstrb_i;
      end
      if (s_q.bvalid && s_axi_bready_i) begin
         s_d.bvalid = 1'b0;
      end
      // Input sampling and change flags
      for (int i = 0; i < NGP; i++) begin
         t = GPI_TERM[i];
         if (field(s_q.route, t) == C_GPI) begin
            s_d.general_input_levels[i] = term_in_i[t];
            if (term_in_i[t] != s_q.general_input_levels[i]) begin
               ev[i] = 1'b1;
               s_d.chg[i] = 1'b1;
            end
         end
      end
      // Register writes
      if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = RESP_OKAY;
         case (s_q.awaddr)
            ADDR_CHG: begin
               // Write one clears; a new change in the same cycle wins
               if (s_q.wstrb[0]) begin
                  s_d.chg = (s_q.chg & ~s_q.wdata[4:0]) | ev;
               end
            end
            ADDR_GPO: begin
               if (s_q.wstrb[0]) begin
                  s_d.general_output_levels = s_q.wdata[4:0];
               end
            end
            ADDR_ROUTE: begin
               rt = s_q.route;
               for (int b = 0; b < 4; b++) begin
                  if (s_q.wstrb[b]) begin
                     rt[8*b +: 8] = s_q.wdata[8*b +: 8];
                  end
               end
               s_d.route = rt & ROUTE_LIVE;
            end
            ADDR_GPI: ;
            default: s_d.bresp = RESP_SLVERR;
         endcase
      end
      // EEPROM defaults override any concurrent software routing write
      if (eeprom_load_i) begin
         s_d.route = eeprom_route_i & ROUTE_LIVE;
      end
      s_d.awready = !s_d.aw_have && !s_d.bvalid;
      s_d.wready = !s_d.w_have && !s_d.bvalid;
      // Read channel
      if (s_q.rvalid && s_axi_rready_i) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rd_addr = s_axi_araddr_i;
         s_d.rresp = RESP_OKAY;
         s_d.rdata = '0;
         case (s_axi_araddr_i)
            ADDR_CHG: s_d.rdata[4:0] = s_q.chg;
            ADDR_GPI: s_d.rdata[4:0] = s_q.general_input_levels;
            ADDR_GPO: s_d.rdata[4:0] = s_q.general_output_levels;
            ADDR_ROUTE: s_d.rdata = s_q.route & ROUTE_LIVE;
            default: s_d.rresp = RESP_SLVERR;
         endcase
      end
      s_d.arready = !s_d.rvalid;
      // Terminal drive
      for (int k = 0; k < NT; k++) begin
         t = 3'(k);
         m = GP_MAP[k];
         dr = term_drive(t, field(s_q.route, t), src,
            m[3] & s_q.general_output_levels[m[2:0]],
            {lock_oe_n_i, serialized_interrupt_oe_n_i, clkrun_oe_n_i});
         s_d.term_oe_n[k] = dr[1];
         s_d.term_out[k] = dr[0];
      end
      s_d.sc_rx = (field(s_q.route, 3'd5) == 4'h4) & term_in_i[5];
      s_d.clk_in = (field(s_q.route, 3'd6) == C_ALT) & term_in_i[6];
      s_d.ser_in = (field(s_q.route, 3'd3) == C_ALT) & term_in_i[3];
      s_d.lock_in = (field(s_q.route, 3'd4) == 4'h2) & term_in_i[4];
   end

   // Only the global reset clears routing, outputs and flags
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q <= ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready_o = s_q.awready;
   assign s_axi_wready_o = s_q.wready;
   assign s_axi_bvalid_o = s_q.bvalid;
   assign s_axi_bresp_o = s_q.bresp;
   assign s_axi_arready_o = s_q.arready;
   assign s_axi_rvalid_o = s_q.rvalid;
   assign s_axi_rresp_o = s_q.rresp;
   assign s_axi_rdata_o = s_q.rdata;
   assign term_out_o = s_q.term_out;
   assign term_oe_n_o = s_q.term_oe_n;
   assign smartcard_debug_receive_o = s_q.sc_rx;
   assign clkrun_in_o = s_q.clk_in;
   assign serialized_interrupt_in_o = s_q.ser_in;
   assign lock_in_o = s_q.lock_in;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence gpo_write_s;
      s_q.aw_have && s_q.w_have && !s_q.bvalid &&
         s_q.awaddr == ADDR_GPO && s_q.wstrb[0];
   endsequence

   sequence load_s;
      eeprom_load_i;
   endsequence

   chk_gpo_write: assert property (gpo_write_s |=>
      s_q.general_output_levels == $past(s_q.wdata[4:0]) && s_q.bvalid)
      else $error("output levels not written");
   chk_reserved_read: assert property (s_q.rvalid &&
      (s_q.rd_addr == ADDR_GPI || s_q.rd_addr == ADDR_GPO) |->
      s_q.rdata[31:5] == '0)
      else $error("reserved level bits not zero");
   chk_route_top_zero: assert property (s_q.route[31:28] == 4'h0)
      else $error("routing top bits set");
   chk_eeprom_load: assert property (load_s |=>
      s_q.route == ($past(eeprom_route_i) & ROUTE_LIVE))
      else $error("eeprom routing not loaded");
   chk_gpi_follow: assert property (field(s_q.route, 3'd0) == C_GPI
      |=> s_q.general_input_levels[0] == $past(term_in_i[0]))
      else $error("input level not followed");
   chk_gpi_hold: assert property (field(s_q.route, 3'd1) != C_GPI
      |=> $stable(s_q.general_input_levels[1]))
      else $error("unrouted input moved");
   chk_change_flag: assert property (field(s_q.route, 3'd2) == C_GPI
      && term_in_i[2] != s_q.general_input_levels[2] |=> s_q.chg[2])
      else $error("change flag not set");
   chk_clkrun_route: assert property (field(s_q.route, 3'd6) == C_ALT
      |=> term_out_o[6] == $past(clkrun_out_i) &&
      term_oe_n_o[6] == $past(clkrun_oe_n_i))
      else $error("clock run not routed");
   chk_scrx_input: assert property (field(s_q.route, 3'd5) == 4'h4
      |=> term_oe_n_o[5] && smartcard_debug_receive_o ==
      $past(term_in_i[5]))
      else $error("debug receive misrouted");
   chk_sctx_route: assert property (field(s_q.route, 3'd4) == 4'h5
      |=> !term_oe_n_o[4] && term_out_o[4] ==
      $past(smartcard_debug_transmit_i))
      else $error("debug transmit misrouted");
   chk_serirq_route: assert property (field(s_q.route, 3'd3) == C_ALT
      |=> term_out_o[3] == $past(serialized_interrupt_out_i))
      else $error("serial irq misrouted");
   chk_t2_irq7: assert property (field(s_q.route, 3'd2) == 4'hf
      |=> !term_oe_n_o[2] && term_out_o[2] == $past(irq_i[7]))
      else $error("terminal 2 irq7 misrouted");
   chk_t1_intb: assert property (field(s_q.route, 3'd1) == 4'h2
      |=> term_out_o[1] == $past(pci_int_i[1]))
      else $error("terminal 1 intb misrouted");
   chk_t0_gpo: assert property (field(s_q.route, 3'd0) == C_GPO
      |=> !term_oe_n_o[0] && term_out_o[0] == $past(s_q.general_output_levels[0]))
      else $error("terminal 0 output misrouted");
   chk_t0_reserved: assert property (field(s_q.route, 3'd0) == 4'h7
      |=> term_oe_n_o[0] [*1])
      else $error("reserved code drives terminal 0");
endmodule // gpio_route

// ### verif/terminal_board.sv
// Purpose: Board model of the seven multifunction terminals
// Assumes: Board sets the level of each released line from the bench
// Notes:   A terminal that drives decides the wire level on its own
`timescale 1ns/10ps
module terminal_board (
   // Device side
   input wire logic [6:0] term_out_i,
   input wire logic [6:0] term_oe_n_i,
   // Bench side
   input wire logic [6:0] board_lvl_i,
   output logic [6:0] term_lvl_o
);
   // ----------------------------------------------------------------
   // Wire level
   // ----------------------------------------------------------------
   // No keeper: a released line never holds the last driven value
   always_comb begin
      for (int k = 0; k < 7; k++) begin
         term_lvl_o[k] = term_oe_n_i[k] ? board_lvl_i[k] : term_out_i[k];
      end
   end
endmodule // terminal_board

// ### verif/testbench.sv
// Purpose: Register and routing checks of the GPIO routing block
// Assumes: Single write and read at a time on the AXI4-Lite port
// Notes:   Every routing code of every terminal is walked
`timescale 1ns/10ps
module testbench;
   import gpio_route_pkg::*;
   logic core_clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, eload;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, eword, rd;
   logic [1:0] bresp, rresp, rsp;
   logic [30:0] src;
   logic [6:0] board, lvl, tout, toe_n;
   logic sc_rx, clk_in, ser_in, lock_in, alt_oe_n;
   int fails = 0;
   int samples_checked = 0;
   // Code per terminal: digit or lowercase a-f = IRQ line, '.' = terminal undriven
   string tab[7] = '{".oA345..p9abE.wf", ".oB3F5..p9abE.wf",
      ".o.345..p.aCRTw7", ".S23456789abcdef", ".oL34X..p9D.Rkwf",
      ".o.3.5..p9.FEkwf", ".K23456789abcdef"};
   gpio_route dut (.core_clk_i(core_clk), .arst_n_i(arst_n),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .eeprom_load_i(eload),
      .eeprom_route_i(eword), .irq_i(src[15:0]), .pci_int_i(src[19:16]),
      .card_audio_pwm_i(src[20]), .firewire_activity_led_i(src[21]),
      .socket_activity_led_i(src[22]), .led_a_one_i(src[23]),
      .ring_indicate_output_i(src[24]),
      .test_multiplexer_output_i(src[25]),
      .wake_event_output_i(src[26]),
      .smartcard_debug_transmit_i(src[27]), .clkrun_out_i(src[28]),
      .clkrun_oe_n_i(alt_oe_n), .serialized_interrupt_out_i(src[29]),
      .serialized_interrupt_oe_n_i(alt_oe_n), .lock_out_i(src[30]),
      .lock_oe_n_i(alt_oe_n), .smartcard_debug_receive_o(sc_rx),
      .clkrun_in_o(clk_in), .serialized_interrupt_in_o(ser_in),
      .lock_in_o(lock_in), .term_in_i(lvl), .term_out_o(tout),
      .term_oe_n_o(toe_n));
   terminal_board board_model (.term_out_i(tout), .term_oe_n_i(toe_n),
      .board_lvl_i(board), .term_lvl_o(lvl));
   // ----------------------------------------------------------------
   // Clock, verdict and watchdog
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic test_done();
      if (fails == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      test_done();
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
         input string msg);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen,
            exp);
      end
   endtask
   // ----------------------------------------------------------------
   // AXI4-Lite master
   // ----------------------------------------------------------------
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
         output logic [1:0] r);
      bit aw_ok;
      bit w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge core_clk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge core_clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
         output logic [1:0] r);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge core_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge core_clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   function automatic int src_of(byte ch);
      case (ch)
         "A", "B", "C", "D": return 16 + ch - "A";
         "p": return S_PWM;
         "F": return S_FW;
         "k": return S_SKT;
         "E": return S_LEDA;
         "R": return S_RI;
         "T": return S_TMUX;
         "w": return S_WAKE;
         "X": return S_SCTX;
         "K": return S_CLK;
         "S": return S_SER;
         "L": return S_LOCK;
         "o": return -2;
         ".": return -1;
         default: return (ch >= "a") ? ch - "a" + 10 : ch - "0";
      endcase
   endfunction
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      int idx;
      {awvalid, wvalid, bready, arvalid, rready, eload, alt_oe_n} = '0;
      {awaddr, araddr, wdata, eword} = '0;
      src = '0;
      board = '0;
      arst_n = 1'b0;
      repeat (2) @(posedge core_clk);
      chk(32'(toe_n), 32'(OE_N_RST), "oe in reset");
      arst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      axi_rd(ADDR_ROUTE, rd, rsp);
      chk(rd, 32'h0000_1000, "route reset");
      axi_rd(ADDR_GPO, rd, rsp);
      chk(rd, 32'h0, "gpo reset");
      axi_wr(ADDR_GPO, 32'hffff_ffff, rsp);
      axi_rd(ADDR_GPO, rd, rsp);
      chk(rd, 32'h1f, "gpo bits");
      axi_wr(ADDR_GPI, 32'hffff_ffff, rsp);
      chk(32'(rsp), 32'(RESP_OKAY), "gpi write");
      axi_rd(12'h000, rd, rsp);
      chk(32'(rsp), 32'(RESP_SLVERR), "unmapped resp");
      chk(rd, 32'h0, "unmapped data");
      axi_wr(ADDR_ROUTE, 32'hffff_ffff, rsp);
      axi_rd(ADDR_ROUTE, rd, rsp);
      chk(rd, 32'h0fff_ffff, "route top");
      // All general terminals as inputs
      board <= 7'h35;
      axi_wr(ADDR_ROUTE, 32'h0, rsp);
      repeat (3) @(posedge core_clk);
      chk(32'(toe_n), 32'h7f, "input undriven");
      axi_rd(ADDR_GPI, rd, rsp);
      chk(rd, 32'h1d, "gpi levels");
      axi_wr(ADDR_CHG, 32'h1f, rsp);
      axi_rd(ADDR_CHG, rd, rsp);
      chk(rd, 32'h0, "flags cleared");
      board <= 7'h34;
      axi_rd(ADDR_CHG, rd, rsp);
      chk(rd, 32'h01, "flag set");
      axi_wr(ADDR_CHG, 32'h01, rsp);
      axi_rd(ADDR_CHG, rd, rsp);
      chk(rd, 32'h0, "flag clear");
      // Outputs on terminals 0,1,2,4,5; inputs must hold
      axi_wr(ADDR_GPO, 32'h15, rsp);
      axi_wr(ADDR_ROUTE, 32'h0011_0111, rsp);
      board <= 7'h4a;
      repeat (3) @(posedge core_clk);
      chk(32'(tout), 32'h25, "gpo drive");
      chk(32'(toe_n), 32'h48, "gpo enable");
      axi_rd(ADDR_GPI, rd, rsp);
      chk(rd, 32'h1c, "gpi hold");
      // Walk every code of every terminal, selected source vs rest
      for (int t = 0; t < NT; t++) begin
         for (int c = 0; c < 16; c++) begin
            for (int p = 0; p < 2; p++) begin
               idx = src_of(tab[t][c]);
               src <= {31{~p[0]}} ^ ((idx >= 0) ? 31'(1) << idx : 31'h0);
               alt_oe_n <= p[0];
               board <= {7{p[0]}};
               if (idx == -2) axi_wr(ADDR_GPO, {27'h0, {5{p[0]}}}, rsp);
               axi_wr(ADDR_ROUTE, 32'(c) << (FW * t), rsp);
               repeat (3) @(posedge core_clk);
               chk(32'(toe_n[t]), 32'(idx == -1 || (idx >= S_CLK && p[0])),
                  "code enable");
               chk(32'(tout[t]), 32'(idx != -1 && p[0]),
                  "code level");
               case (idx)
                  S_CLK: chk(32'(clk_in), 32'(p), "clock run in");
                  S_SER: chk(32'(ser_in), 32'(p), "serial in");
                  S_LOCK: chk(32'(lock_in), 32'(p), "lock in");
                  default: if (t == 5 && c == 4) begin
                     chk(32'(sc_rx), 32'(p), "sc rx");
                  end
               endcase
            end
         end
      end
      @(posedge core_clk);
      eword <= 32'hffff_1234;
      eload <= 1'b1;
      @(posedge core_clk);
      eload <= 1'b0;
      axi_rd(ADDR_ROUTE, rd, rsp);
      chk(rd, 32'h0fff_1234, "eeprom load");
      axi_wr(ADDR_GPO, 32'h1f, rsp);
      @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      axi_rd(ADDR_ROUTE, rd, rsp);
      chk(rd, 32'h0000_1000, "route global reset");
      axi_rd(ADDR_GPO, rd, rsp);
      chk(rd, 32'h0, "gpo global reset");
      test_done();
   end
endmodule // testbench
